// >>> include/sfs_map.svh
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH
// soft-start timing, in switching clock cycles
`define SFS_DELAY_CYCLES   11'd1024
`define SFS_RAMP_CYCLES    11'd1024
`define SFS_PG_DELAY       2'd3
// reference code: 10 bits, full scale is 0.8 V
`define SFS_REF_W          10
`define SFS_REF_FULL       10'h3ff
// undervoltage check unmasks at 80 % of full scale
`define SFS_REF_UV_EN      10'h333
// consecutive overcurrent cycles that trip the latch
`define SFS_OC_TRIP        3'd7
`endif

// >>> include/sfs_pkg.sv
package sfs_pkg;
	typedef enum logic [2:0] {
		SFS_OFF,
		SFS_DELAY,
		SFS_RAMP,
		SFS_RUN,
		SFS_LATCH
	} sfs_state_t;
	typedef logic [9:0] sfs_ref_t;
endpackage

// >>> hdl/sfs_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a vector of asynchronous comparator flags
module sfs_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta_q;

	// first stage is read only by the second
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule

// >>> hdl/sfs_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] start soft-start only with both supplies good and enable released
// [R2] wait 1024 cycles, then ramp reference over 1024 cycles
// [R3] reference rises monotonically from zero to full scale and stays
// [R4] power-good released three cycles after the ramp completes
// [R5] undervoltage masked during ramp until reference reaches 80 percent
// [R6] overvoltage always checked; feedback-loss check active during soft-start
// [R7] low-side gate held off by the loop until the first pwm pulse; logic holds it only in soft-start, run arms it without one
// [R8] low-side mask does not block the overvoltage clamp
// [R9] power-good low when output leaves the +12.5/-25 percent window
// [R10] undervoltage outside soft-start: both gates off, power-good low, latched
// [R11] overvoltage latches, high-side off, low-side on until below half reference
// [R12] while latched, low-side turns on whenever output exceeds overvoltage level
// [R13] disabled: low-side clamps on overvoltage; enable rising clears and starts
// [R14] undervoltage during soft-start restarts delay and ramp, no latch
// [R15] overcurrent forces low-side on at least for the rest of the cycle
// [R16] seventh consecutive overcurrent cycle latches off with both gates off
// [R17] system cycles supply or enable to leave a latched fault
// [R18] power-good drops in the same cycle the voltage fault latches
// [R19] comparator inputs synchronised; faults cleared on disable or lockout
module sfs_sequencer (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             ctrlSupplyOk,
	input  wire logic             driverSupplyOk,
	input  wire logic             enableIn,
	input  wire logic             senseOver,
	input  wire logic             senseUnder,
	input  wire logic             senseBelowHalf,
	input  wire logic             feedbackLost,
	input  wire logic             overcurrentEvent,
	input  wire logic             pwmPulse,
	input  wire logic             loopHighReq,
	input  wire logic             loopLowReq,
	output logic                  highSideGate,
	output logic                  lowSideGate,
	output logic                  powerGoodOut,
	output sfs_pkg::sfs_ref_t     refCode,
	output logic                  softStartActive,
	output logic                  faultLatched
);
	import sfs_pkg::*;
	`include "sfs_map.svh"

	// synchronised comparator and pin flags
	logic [7:0] syncFlags;
	logic       supOk;
	logic       enS;
	logic       ovS;
	logic       uvS;
	logic       halfS;
	logic       fbS;
	logic       ocS;
	logic       pwmS;

	sfs_sync #(
		.W(8)
	) u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.asyncIn ({ctrlSupplyOk & driverSupplyOk, enableIn, senseOver, senseUnder,
			senseBelowHalf, feedbackLost, overcurrentEvent, pwmPulse}), // R19
		.syncOut (syncFlags)
	);
	assign {supOk, enS, ovS, uvS, halfS, fbS, ocS, pwmS} = syncFlags;

	sfs_state_t state_q;
	sfs_state_t state_d;
	logic [10:0] cnt_q;
	logic [10:0] cnt_d;
	sfs_ref_t    ref_q;
	sfs_ref_t    ref_d;
	logic [1:0]  pgCnt_q;
	logic [1:0]  pgCnt_d;
	logic [2:0]  ocCnt_q;
	logic [2:0]  ocCnt_d;
	logic        enPrev_q;
	logic        lsArmed_q;
	logic        lsArmed_d;
	logic        ovClamp_q;
	logic        ovClamp_d;
	logic        ocHold_q;
	logic        pgDone_q;
	logic        pgDone_d;
	logic        hs_d;
	logic        ls_d;
	logic        pg_d;

	// qualification: lockout or disable drops everything but the overvoltage clamp back to idle
	wire logic goQual   = supOk & enS; // R1
	wire logic enRise   = enS & ~enPrev_q; // R13
	wire logic inSs     = (state_q == SFS_DELAY) || (state_q == SFS_RAMP);
	wire logic uvArmed  = (state_q == SFS_RAMP) && (ref_q >= `SFS_REF_UV_EN); // R5
	wire logic uvTrip   = uvS & (uvArmed | (state_q == SFS_RUN));
	wire logic ssRetry  = uvS & uvArmed; // R14
	wire logic ovTrip   = ovS & (state_q != SFS_OFF); // R6
	wire logic fbTrip   = fbS & inSs; // R6
	wire logic ocTrip   = ocS && (ocCnt_q == `SFS_OC_TRIP - 3'd1); // R16
	wire logic hardTrip = (uvTrip & ~ssRetry) | fbTrip | ocTrip; // R10
	wire logic rampDone = (state_q == SFS_RAMP) && (ref_q == `SFS_REF_FULL);
	wire logic inWindow = ~ovS & ~uvS; // R9

	// sequencing state machine
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		ref_d   = ref_q;
		unique case (state_q)
			SFS_OFF: begin
				cnt_d = '0;
				ref_d = '0;
				if (goQual) begin
					state_d = SFS_DELAY; // R1
				end
			end
			SFS_DELAY: begin
				cnt_d = cnt_q + 11'd1;
				if (cnt_q == `SFS_DELAY_CYCLES - 11'd1) begin
					state_d = SFS_RAMP; // R2
					cnt_d   = '0;
				end
			end
			SFS_RAMP: begin
				// one lsb per cycle; 1023 steps plus the final hold make 1024 cycles
				if (ref_q != `SFS_REF_FULL) begin
					ref_d = ref_q + sfs_ref_t'(1); // R3
				end else begin
					state_d = SFS_RUN;
				end
			end
			SFS_RUN: begin
				ref_d = `SFS_REF_FULL; // R3
			end
			SFS_LATCH: begin
				ref_d = ref_q;
			end
		endcase
		if (ssRetry) begin
			state_d = SFS_DELAY; // R14
			cnt_d   = '0;
			ref_d   = '0;
		end
		if (hardTrip | ovTrip) begin
			state_d = SFS_LATCH; // R11
		end
		if (!goQual) begin
			state_d = SFS_OFF; // R19
			cnt_d   = '0;
			ref_d   = '0;
		end
	end

	// overcurrent counter: clears on a clean cycle
	assign ocCnt_d = (!goQual || !ocS) ? 3'd0 :
		(ocCnt_q == `SFS_OC_TRIP) ? ocCnt_q : ocCnt_q + 3'd1; // R16

	// power-good delay after ramp end
	assign pgCnt_d  = (state_q != SFS_RUN) ? 2'd0 :
		(pgCnt_q == `SFS_PG_DELAY) ? pgCnt_q : pgCnt_q + 2'd1;
	assign pgDone_d = (state_q == SFS_RUN) && (pgCnt_q == `SFS_PG_DELAY - 2'd1 || pgDone_q); // R4

	// low-side enable by loop only after first pwm pulse in soft-start; run and latch arm it at once
	assign lsArmed_d = inSs ? (lsArmed_q | pwmS) : (state_q != SFS_OFF); // R7

	// overvoltage clamp holds until output falls below half reference
	assign ovClamp_d = ovS ? 1'b1 : (halfS ? 1'b0 : ovClamp_q); // R11 R12 R13

	// gate and power-good decisions
	always_comb begin
		hs_d = 1'b0;
		ls_d = 1'b0;
		pg_d = 1'b0;
		if (ovS | ovClamp_q) begin
			ls_d = 1'b1; // R8 R12 R13
		end else if (state_q == SFS_OFF || state_q == SFS_LATCH || hardTrip) begin
			ls_d = 1'b0; // R10 R16
		end else if (ocS | ocHold_q) begin
			ls_d = 1'b1; // R15
		end else begin
			hs_d = loopHighReq;
			ls_d = loopLowReq & lsArmed_d; // R7
		end
		// drop in the very cycle a fault latches, no extra delay
		pg_d = pgDone_d & inWindow & ~hardTrip & ~ovTrip & goQual; // R9 R18
	end

	// registers; restart on enable rise clears the disabled clamp
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q   <= SFS_OFF;
			cnt_q     <= '0;
			ref_q     <= '0;
			pgCnt_q   <= '0;
			ocCnt_q   <= '0;
			enPrev_q  <= 1'b0;
			lsArmed_q <= 1'b0;
			ovClamp_q <= 1'b0;
			ocHold_q  <= 1'b0;
			pgDone_q  <= 1'b0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			ref_q     <= ref_d;
			pgCnt_q   <= pgCnt_d;
			ocCnt_q   <= ocCnt_d;
			enPrev_q  <= enS;
			lsArmed_q <= lsArmed_d;
			ovClamp_q <= enRise ? 1'b0 : ovClamp_d; // R13
			ocHold_q  <= ocS & goQual; // R15
			pgDone_q  <= pgDone_d;
		end
	end

	// outputs straight from flops
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			highSideGate    <= 1'b0;
			lowSideGate     <= 1'b0;
			powerGoodOut    <= 1'b0;
			refCode         <= '0;
			softStartActive <= 1'b0;
			faultLatched    <= 1'b0;
		end else begin
			highSideGate    <= hs_d & ~ls_d;
			lowSideGate     <= ls_d;
			powerGoodOut    <= pg_d;
			refCode         <= ref_d;
			softStartActive <= (state_d == SFS_DELAY) || (state_d == SFS_RAMP);
			faultLatched    <= (state_d == SFS_LATCH);
		end
	end
endmodule

// >>> tb/sfs_sequencer_assertions.sv
`timescale 1ns/1ps
// port checks; inputs reach the outputs through two sync flops and the output flop
module sfs_sequencer_assertions (
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire logic              ctrlSupplyOk,
	input wire logic              driverSupplyOk,
	input wire logic              enableIn,
	input wire logic              overcurrentEvent,
	input wire logic              highSideGate,
	input wire logic              lowSideGate,
	input wire logic              powerGoodOut,
	input wire sfs_pkg::sfs_ref_t refCode,
	input wire logic              softStartActive,
	input wire logic              faultLatched
);
	import sfs_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic [10:0] zeroCnt_q;
	// length of the idle stretch at zero reference
	always_ff @(posedge sys_clk)
		zeroCnt_q <= (sys_rst || !softStartActive || refCode != 10'h0) ? 11'h0 : zeroCnt_q + 11'h1;
	property p_refStep; !$stable(refCode) |-> refCode == 10'h0 || refCode == $past(refCode) + 10'h1; endproperty
	a_refStep: assert property (p_refStep) else $error("ref step");
	property p_pgFull; $rose(powerGoodOut) |-> refCode == 10'h3ff && !faultLatched; endproperty
	a_pgFull: assert property (p_pgFull) else $error("pg early");
	property p_hsOff; faultLatched |-> !highSideGate; endproperty
	a_hsOff: assert property (p_hsOff) else $error("hs on in fault");
	property p_pgFault; faultLatched |-> !powerGoodOut; endproperty
	a_pgFault: assert property (p_pgFault) else $error("pg in fault");
	property p_uvMask; softStartActive && $past(refCode) < 10'h333 |-> refCode >= $past(refCode); endproperty
	a_uvMask: assert property (p_uvMask) else $error("uv not masked");
	property p_delayLen; softStartActive && refCode == 10'h1 |-> zeroCnt_q inside {[1024:1026]}; endproperty
	a_delayLen: assert property (p_delayLen) else $error("delay length");
	property p_start; $rose(softStartActive) |-> $past(enableIn, 2) && $past(ctrlSupplyOk, 2) && $past(driverSupplyOk, 2); endproperty
	a_start: assert property (p_start) else $error("start unqualified");
	property p_ocForce; softStartActive && $past(overcurrentEvent, 3) && $past(overcurrentEvent, 4) |-> lowSideGate; endproperty
	a_ocForce: assert property (p_ocForce) else $error("oc ls off");
endmodule
bind sfs_sequencer sfs_sequencer_assertions chk_u (.*);

// >>> tb/sfs_plant.sv
`timescale 1ns/1ps
// comparator and loop stand-in; the bench picks one raised flag at a time
module sfs_plant (
	input  wire logic       sys_clk,
	input  wire logic [2:0] fault,
	input  wire logic       pwmOn,
	output logic            senseOver,
	output logic            senseUnder,
	output logic            senseBelowHalf,
	output logic            overcurrentEvent,
	output logic            pwmPulse = 1'b0,
	output logic            loopLowReq
);
	// one flag per code, so over and under never show together
	assign senseOver        = fault == 3'd1;
	assign senseUnder       = fault == 3'd2;
	assign senseBelowHalf   = fault == 3'd3;
	assign overcurrentEvent = fault == 3'd4;
	assign loopLowReq       = ~pwmPulse;
	// pwm moves off the sampling edge; low side asked for while high rests
	always @(negedge sys_clk) begin
		pwmPulse <= pwmOn & ~pwmPulse;
	end
endmodule

// >>> tb/tb_softstart_fault_sequencer.sv
`timescale 1ns/1ps
`include "sfs_map.svh"
// four-state compare, counted
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_softstart_fault_sequencer;
	import sfs_pkg::*;
	logic       sys_clk, sys_rst, ctrlSupplyOk, driverSupplyOk, enableIn, pwmOn, fbLost;
	logic       senseOver, senseUnder, senseBelowHalf, overcurrentEvent, pwmPulse, loopLowReq;
	logic       highSideGate, lowSideGate, powerGoodOut, softStartActive, faultLatched;
	sfs_ref_t   refCode;
	logic [2:0] fault;
	int         error_cnt, checked, n, k;
	sfs_sequencer dut_u (.sys_clk, .sys_rst, .ctrlSupplyOk, .driverSupplyOk, .enableIn,
		.senseOver, .senseUnder, .senseBelowHalf, .feedbackLost(fbLost), .overcurrentEvent,
		.pwmPulse, .loopHighReq(pwmPulse), .loopLowReq, .highSideGate, .lowSideGate,
		.powerGoodOut, .refCode, .softStartActive, .faultLatched);
	sfs_plant plant_u (.sys_clk, .fault, .pwmOn, .senseOver, .senseUnder, .senseBelowHalf,
		.overcurrentEvent, .pwmPulse, .loopLowReq);
	// helpers: stimulus moves on falling edges only
	task cyc(input int c); repeat (c) @(negedge sys_clk); endtask
	task pulse(input logic [2:0] f); fault = f; cyc(4); fault = 3'd0; cyc(2); endtask
	task stop_test();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// bounded wait on soft-start (0) or power-good (1), cycles left in n
	task waitFor(input int i, input logic v);
		n = 0;
		while ((i == 1 ? powerGoodOut : softStartActive) !== v) begin
			if (n == 4000) begin
				error_cnt++;
				stop_test();
			end
			cyc(1);
			n++;
		end
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// sequence: start, ov, disabled clamp, uv mask and restart, uv latch, oc
	initial begin
		{sys_rst, ctrlSupplyOk, driverSupplyOk, enableIn, pwmOn, fault} = 8'h90;
		{error_cnt, checked} = 0;
		fbLost = 1'b0;
		k = $urandom(32'h06c1de5e);
		cyc(16);
		sys_rst = 1'b0;
		ctrlSupplyOk = 1'b1;
		cyc(20);
		`CHK("idle", 15'h0, {highSideGate, lowSideGate, powerGoodOut, softStartActive, faultLatched, refCode})
		driverSupplyOk = 1'b1;
		waitFor(0, 1'b1);
		cyc(8);
		`CHK("ls before pwm", 1'b0, lowSideGate)
		waitFor(0, 1'b0);
		`CHK("ss length", 32'(`SFS_DELAY_CYCLES) + 32'(`SFS_RAMP_CYCLES) - 8, n)
		waitFor(1, 1'b1);
		`CHK("pg delay", 3, n)
		`CHK("ref full", 10'h3ff, refCode)
		fault = 3'd1;
		cyc(4);
		`CHK("ov", 4'h5, {highSideGate, lowSideGate, powerGoodOut, faultLatched})
		fault = 3'd3;
		cyc(4);
		`CHK("ov release", 1'b0, lowSideGate)
		fault = 3'd1;
		cyc(4);
		`CHK("ov again", 1'b1, lowSideGate)
		{enableIn, fault} = 4'h1;
		cyc(8);
		`CHK("off clamp", 1'b1, lowSideGate)
		{enableIn, fault} = 4'h8;
		cyc(4);
		`CHK("clamp clear", 2'h0, {lowSideGate, faultLatched})
		waitFor(0, 1'b1);
		cyc(1400);
		pulse(3'd2);
		`CHK("uv masked", 2'h2, {refCode != 10'h0, faultLatched})
		cyc(450 + $urandom % 150);
		pulse(3'd2);
		`CHK("uv restart", 12'h800, {softStartActive, faultLatched, refCode})
		pwmOn = 1'b1;
		waitFor(1, 1'b1);
		pulse(3'd2);
		`CHK("uv latch", 4'h1, {highSideGate, lowSideGate, powerGoodOut, faultLatched})
		ctrlSupplyOk = 1'b0;
		cyc(4);
		`CHK("lockout clears", 1'b0, faultLatched)
		ctrlSupplyOk = 1'b1;
		waitFor(0, 1'b1);
		k = 3 + $urandom % 4;
		fault = 3'd4;
		cyc(3);
		`CHK("oc forces ls", 1'b1, lowSideGate)
		cyc(k - 3);
		fault = 3'd0;
		cyc(4);
		`CHK("oc count cleared", 1'b0, faultLatched)
		fault = 3'd4;
		cyc(12);
		`CHK("oc latch", 3'h1, {highSideGate, lowSideGate, faultLatched})
		// feedback loss in soft-start latches with both gates off
		{enableIn, fault} = 4'h0;
		cyc(4);
		enableIn = 1'b1;
		waitFor(0, 1'b1);
		fbLost = 1'b1;
		cyc(4);
		`CHK("fb loss", 4'h1, {highSideGate, lowSideGate, powerGoodOut, faultLatched})
		stop_test();
	end
endmodule
